/* pkg/dctm_pkg.sv */
// dctm_pkg: register map, field positions, reset values and modes of the dual counter/timer
// assumes a 32-bit classic wishbone slave with word-aligned registers
`default_nettype none
package dctm_pkg;
  // register byte addresses (0x88 printed, multiple of four)
  localparam logic [7:0] ADDR_RUN_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_MODE_SELECT  = 8'h8C;
  localparam logic [7:0] ADDR_CLOCK_SCALE  = 8'h90;
  localparam logic [7:0] ADDR_A_LOW        = 8'h94;
  localparam logic [7:0] ADDR_A_HIGH       = 8'h98;
  localparam logic [7:0] ADDR_B_LOW        = 8'h9C;
  localparam logic [7:0] ADDR_B_HIGH       = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hA4;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'hA8;
  localparam logic [7:0] ADDR_INPUT_CONFIG = 8'hAC;
  // timer_run_control fields
  localparam int RC_B_OVF = 7;
  localparam int RC_B_RUN = 6;
  localparam int RC_A_OVF = 5;
  localparam int RC_A_RUN = 4;
  // timer_mode_select fields: low nibble timer a, high nibble timer b
  localparam int MS_MODE_LSB = 0;
  localparam int MS_CT       = 2;
  localparam int MS_GATE     = 3;
  localparam int MS_B_BASE   = 4;
  // clock_scale_control fields
  localparam int CS_SCALE_LSB = 0;
  localparam int CS_A_SYSCLK  = 3;
  localparam int CS_B_SYSCLK  = 4;
  // ext_input_config fields
  localparam int IC_A_POL = 3;
  localparam int IC_B_POL = 7;
  // irq status bits
  localparam int IS_A = 0;
  localparam int IS_B = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // prescale divisors selected by the scale field
  localparam int PRESCALE_0 = 12;
  localparam int PRESCALE_1 = 4;
  localparam int PRESCALE_2 = 48;
  typedef enum logic [1:0] {
    DCTM_MODE_13BIT  = 2'h0,
    DCTM_MODE_16BIT  = 2'h1,
    DCTM_MODE_RELOAD = 2'h2,
    DCTM_MODE_SPLIT  = 2'h3
  } dctm_mode_t;
endpackage
`default_nettype wire

/* src/dctm_counter.sv */
// dctm_counter: one 16-bit count pair stepping per mode, with split high byte
// assumes tick and enable qualifiers computed by the parent
`default_nettype none
module dctm_counter (
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  input  wire logic [1:0]    i_mode,
  input  wire logic          i_low_step,
  input  wire logic          i_high_step,
  input  wire logic          i_wr_low,
  input  wire logic          i_wr_high,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_low,
  output logic      [7:0]    o_high,
  output logic               o_ovf,
  output logic               o_high_ovf
);
  logic [7:0] low_q;
  logic [7:0] high_q;
  assign o_low  = low_q;
  assign o_high = high_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    o_ovf      = 1'b0;
    o_high_ovf = 1'b0;
    case (dctm_pkg::dctm_mode_t'(i_mode))
      dctm_pkg::DCTM_MODE_13BIT:  o_ovf = i_low_step && low_q[4:0] == 5'h1F && high_q == 8'hFF;
      dctm_pkg::DCTM_MODE_16BIT:  o_ovf = i_low_step && low_q == 8'hFF && high_q == 8'hFF;
      dctm_pkg::DCTM_MODE_RELOAD: o_ovf = i_low_step && low_q == 8'hFF;
      dctm_pkg::DCTM_MODE_SPLIT: begin
        o_ovf      = i_low_step && low_q == 8'hFF;
        o_high_ovf = i_high_step && high_q == 8'hFF;
      end
      default: o_ovf = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // software write wins over a count in the same cycle; no clear on run
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      low_q <= 8'h00;
    end else if (i_wr_low) begin
      low_q <= i_wdata;
    end else if (i_low_step) begin
      case (dctm_pkg::dctm_mode_t'(i_mode))
        dctm_pkg::DCTM_MODE_13BIT: begin
          // upper three bits are don't-care; kept zero
          low_q <= {3'h0, low_q[4:0] + 5'h01};
        end
        dctm_pkg::DCTM_MODE_RELOAD: begin
          low_q <= (low_q == 8'hFF) ? high_q : low_q + 8'h01;
        end
        default: low_q <= low_q + 8'h01;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      high_q <= 8'h00;
    end else if (i_wr_high) begin
      high_q <= i_wdata;
    end else begin
      case (dctm_pkg::dctm_mode_t'(i_mode))
        dctm_pkg::DCTM_MODE_13BIT: begin
          if (i_low_step && low_q[4:0] == 5'h1F) begin
            high_q <= high_q + 8'h01;
          end
        end
        dctm_pkg::DCTM_MODE_16BIT: begin
          if (i_low_step && low_q == 8'hFF) begin
            high_q <= high_q + 8'h01;
          end
        end
        dctm_pkg::DCTM_MODE_SPLIT: begin
          if (i_high_step) begin
            high_q <= high_q + 8'h01;
          end
        end
        default: high_q <= high_q;
      endcase
    end
  end
endmodule
`default_nettype wire

/* src/dctm_top.sv */
// dctm_top: two counter/timers with 13/16/8-reload modes, split on timer a only, behind a wishbone slave
// assumes synchronous pins, one 10 MHz clock, single-cycle classic wishbone master
//
// Register access over Wishbone was left to the implementer.
`default_nettype none
module dctm_top #(
  parameter int PRESCALE_0 = dctm_pkg::PRESCALE_0,
  parameter int PRESCALE_1 = dctm_pkg::PRESCALE_1,
  parameter int PRESCALE_2 = dctm_pkg::PRESCALE_2
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_timer_a_event_pin,
  input  wire logic        i_timer_b_event_pin,
  input  wire logic        i_ext_gate_input_a,
  input  wire logic        i_ext_gate_input_b,
  input  wire logic        i_timer_a_irq_enable,
  input  wire logic        i_timer_b_irq_enable,
  input  wire logic        i_timer_a_vector_ack,
  input  wire logic        i_timer_b_vector_ack,
  output logic             o_timer_a_irq,
  output logic             o_timer_b_irq,
  output logic             o_timer_b_baud_tick,
  output logic             o_irq
);
  logic [7:0] run_ctl_q;
  logic [7:0] mode_sel_q;
  logic [7:0] clk_scale_q;
  logic [7:0] in_cfg_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [7:0] pre_cnt_q;
  logic       pre_tick;
  logic [1:0] evt_q;
  logic       evt_fall_a;
  logic       evt_fall_b;
  logic       gate_a;
  logic       gate_b;
  logic       a_low_step;
  logic       a_high_step;
  logic       b_step;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic       a_split;
  logic [7:0] a_low;
  logic [7:0] a_high;
  logic [7:0] b_low;
  logic [7:0] b_high;
  logic       a_ovf;
  logic       a_high_ovf;
  logic       b_ovf;
  logic       set_a;
  logic       set_b;
  logic       req;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] pre_div;

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by both timers
  function automatic logic tick_sel(input logic ct, input logic sys, input logic fall, input logic pre);
    if (ct) begin
      return fall;
    end
    return sys ? 1'b1 : pre;
  endfunction

  function automatic logic gate_ok(input logic run, input logic gate, input logic pin, input logic pol);
    return run && (!gate || (pin == pol));
  endfunction

  assign mode_a  = mode_sel_q[dctm_pkg::MS_MODE_LSB +: 2];
  assign mode_b  = mode_sel_q[dctm_pkg::MS_B_BASE + dctm_pkg::MS_MODE_LSB +: 2];
  assign a_split = dctm_pkg::dctm_mode_t'(mode_a) == dctm_pkg::DCTM_MODE_SPLIT;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: one-cycle tick every divisor clocks
  always_comb begin
    case (clk_scale_q[dctm_pkg::CS_SCALE_LSB +: 2])
      2'h0:    pre_div = PRESCALE_0[7:0];
      2'h1:    pre_div = PRESCALE_1[7:0];
      2'h2:    pre_div = PRESCALE_2[7:0];
      default: pre_div = PRESCALE_0[7:0];
    endcase
  end

  assign pre_tick = pre_cnt_q >= pre_div - 8'h01;

  always_ff @(posedge i_clk) begin
    if (i_reset || pre_tick) begin
      pre_cnt_q <= 8'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event pins are synchronous; one register suffices to see a falling edge.
  // a one-clock hold on the pin is enough for each level to be seen
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      evt_q <= 2'h0;
    end else begin
      evt_q <= {i_timer_b_event_pin, i_timer_a_event_pin};
    end
  end

  assign evt_fall_a = evt_q[0] && !i_timer_a_event_pin;
  assign evt_fall_b = evt_q[1] && !i_timer_b_event_pin;

  // separate polarity bit per timer
  assign gate_a = gate_ok(run_ctl_q[dctm_pkg::RC_A_RUN], mode_sel_q[dctm_pkg::MS_GATE],
                          i_ext_gate_input_a, in_cfg_q[dctm_pkg::IC_A_POL]);
  assign gate_b = gate_ok(run_ctl_q[dctm_pkg::RC_B_RUN], mode_sel_q[dctm_pkg::MS_B_BASE + dctm_pkg::MS_GATE],
                          i_ext_gate_input_b, in_cfg_q[dctm_pkg::IC_B_POL]);

  // timer a low byte keeps its own controls in every mode
  assign a_low_step = gate_a && tick_sel(mode_sel_q[dctm_pkg::MS_CT], clk_scale_q[dctm_pkg::CS_A_SYSCLK],
                                         evt_fall_a, pre_tick);
  // split high byte: internal clock only, run b only
  assign a_high_step = a_split && run_ctl_q[dctm_pkg::RC_B_RUN] &&
                       tick_sel(1'b0, clk_scale_q[dctm_pkg::CS_A_SYSCLK], 1'b0, pre_tick);

  always_comb begin
    if (a_split) begin
      // b ignores run bit and event pin; split setting halts it
      b_step = dctm_pkg::dctm_mode_t'(mode_b) != dctm_pkg::DCTM_MODE_SPLIT &&
               tick_sel(1'b0, clk_scale_q[dctm_pkg::CS_B_SYSCLK], 1'b0, pre_tick);
    end else begin
      b_step = dctm_pkg::dctm_mode_t'(mode_b) != dctm_pkg::DCTM_MODE_SPLIT &&
               gate_b && tick_sel(mode_sel_q[dctm_pkg::MS_B_BASE + dctm_pkg::MS_CT],
                                  clk_scale_q[dctm_pkg::CS_B_SYSCLK], evt_fall_b, pre_tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode: ack one cycle after the strobe, dropped the next cycle
  assign req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr    = req && i_wb_we && i_wb_sel[0];
  assign rd    = req && !i_wb_we;
  assign wbyte = i_wb_dat[7:0];

  dctm_counter u_a (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_mode      (mode_a),
    .i_low_step  (a_low_step),
    .i_high_step (a_high_step),
    .i_wr_low    (wr && i_wb_adr == dctm_pkg::ADDR_A_LOW),
    .i_wr_high   (wr && i_wb_adr == dctm_pkg::ADDR_A_HIGH),
    .i_wdata     (wbyte),
    .o_low       (a_low),
    .o_high      (a_high),
    .o_ovf       (a_ovf),
    .o_high_ovf  (a_high_ovf)
  );

  dctm_counter u_b (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_mode      (mode_b),
    .i_low_step  (b_step),
    .i_high_step (1'b0),
    .i_wr_low    (wr && i_wb_adr == dctm_pkg::ADDR_B_LOW),
    .i_wr_high   (wr && i_wb_adr == dctm_pkg::ADDR_B_HIGH),
    .i_wdata     (wbyte),
    .o_low       (b_low),
    .o_high      (b_high),
    .o_ovf       (b_ovf),
    .o_high_ovf  ()
  );

  // in split mode b's flag belongs to a's high byte
  assign set_a = a_ovf;
  assign set_b = a_split ? a_high_ovf : b_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // control registers; hardware set beats software or vector clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      run_ctl_q <= dctm_pkg::RESET_BYTE;
    end else begin
      if (wr && i_wb_adr == dctm_pkg::ADDR_RUN_CONTROL) begin
        run_ctl_q <= wbyte;
      end else begin
        if (i_timer_a_vector_ack) begin
          run_ctl_q[dctm_pkg::RC_A_OVF] <= 1'b0;
        end
        if (i_timer_b_vector_ack) begin
          run_ctl_q[dctm_pkg::RC_B_OVF] <= 1'b0;
        end
      end
      if (set_a) begin
        run_ctl_q[dctm_pkg::RC_A_OVF] <= 1'b1;
      end
      if (set_b) begin
        run_ctl_q[dctm_pkg::RC_B_OVF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_sel_q  <= dctm_pkg::RESET_BYTE;
      clk_scale_q <= dctm_pkg::RESET_BYTE;
      in_cfg_q    <= dctm_pkg::RESET_BYTE;
      irq_mask_q  <= 2'h0;
    end else if (wr) begin
      case (i_wb_adr)
        dctm_pkg::ADDR_MODE_SELECT:  mode_sel_q  <= wbyte;
        dctm_pkg::ADDR_CLOCK_SCALE:  clk_scale_q <= wbyte;
        dctm_pkg::ADDR_INPUT_CONFIG: in_cfg_q    <= wbyte;
        dctm_pkg::ADDR_IRQ_MASK:     irq_mask_q  <= wbyte[1:0];
        default:                     irq_mask_q  <= irq_mask_q;
      endcase
    end
  end

  // sticky status cleared by read; a set in the read cycle survives
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= ((rd && i_wb_adr == dctm_pkg::ADDR_IRQ_STATUS) ? 2'h0 : irq_stat_q) | {set_b, set_a};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (i_wb_adr)
      dctm_pkg::ADDR_RUN_CONTROL:  rbyte = run_ctl_q;
      dctm_pkg::ADDR_MODE_SELECT:  rbyte = mode_sel_q;
      dctm_pkg::ADDR_CLOCK_SCALE:  rbyte = clk_scale_q;
      dctm_pkg::ADDR_A_LOW:        rbyte = a_low;
      dctm_pkg::ADDR_A_HIGH:       rbyte = a_high;
      dctm_pkg::ADDR_B_LOW:        rbyte = b_low;
      dctm_pkg::ADDR_B_HIGH:       rbyte = b_high;
      dctm_pkg::ADDR_IRQ_STATUS:   rbyte = {6'h00, irq_stat_q};
      dctm_pkg::ADDR_IRQ_MASK:     rbyte = {6'h00, irq_mask_q};
      dctm_pkg::ADDR_INPUT_CONFIG: rbyte = in_cfg_q;
      default:                     rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= rd ? {24'h000000, rbyte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs registered, so the irqs trail their flags and the baud tick trails b_ovf by one clock
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_timer_a_irq       <= 1'b0;
      o_timer_b_irq       <= 1'b0;
      o_timer_b_baud_tick <= 1'b0;
      o_irq               <= 1'b0;
    end else begin
      o_timer_a_irq       <= run_ctl_q[dctm_pkg::RC_A_OVF] && i_timer_a_irq_enable;
      o_timer_b_irq       <= run_ctl_q[dctm_pkg::RC_B_OVF] && i_timer_b_irq_enable;
      o_timer_b_baud_tick <= b_ovf;
      o_irq               <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

/* verification/dctm_properties.sv */
// dctm_properties: bus, interrupt and reset checks on the dctm_top ports
// assumes bind onto dctm_top, one clock domain
`default_nettype none
module dctm_properties (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_timer_a_irq_enable,
  input wire logic        i_timer_b_irq_enable,
  input wire logic        o_timer_a_irq,
  input wire logic        o_timer_b_irq,
  input wire logic        o_timer_b_baud_tick,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_stb) && $past(i_wb_cyc))
    else $error("ack without request");
  rdata_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
    else $error("read data driven without ack");
  irq_a_gate_a: assert property (o_timer_a_irq |-> $past(i_timer_a_irq_enable))
    else $error("timer a request without enable");
  irq_b_gate_a: assert property (o_timer_b_irq |-> $past(i_timer_b_irq_enable))
    else $error("timer b request without enable");
  reset_quiet_a: assert property ($fell(i_reset) |-> !o_wb_ack && !o_irq && !o_timer_a_irq && !o_timer_b_irq)
    else $error("outputs active after reset");
  // baud tick may repeat every cycle with a reload of all ones, so no width check
  cover property ($rose(o_irq));
  cover property ($rose(o_timer_a_irq));
  cover property ($rose(o_timer_b_irq));
endmodule
bind dctm_top dctm_properties u_props (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_timer_a_irq_enable(i_timer_a_irq_enable), .i_timer_b_irq_enable(i_timer_b_irq_enable),
  .o_timer_a_irq(o_timer_a_irq), .o_timer_b_irq(o_timer_b_irq),
  .o_timer_b_baud_tick(o_timer_b_baud_tick), .o_irq(o_irq));
`default_nettype wire

/* verification/dctm_pin_model.sv */
// dctm_pin_model: event and gate pins facing the timers
// assumes tasks called from tb, levels change right after a rising edge
`default_nettype none
module dctm_pin_model (
  input  wire logic i_clk,
  output var logic  o_event_a,
  output var logic  o_event_b,
  output var logic  o_gate_a,
  output var logic  o_gate_b
);
  initial begin
    o_event_a = 1'b1;
    o_event_b = 1'b1;
    o_gate_a  = 1'b0;
    o_gate_b  = 1'b0;
  end
  // each level held two clocks, twice the one clock the sampler needs
  task automatic pulse(input int n);
    repeat (n) begin
      o_event_a <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_event_a <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
  endtask
  task automatic pulse_b(input int n);
    repeat (n) begin
      o_event_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_event_b <= 1'b1;
      repeat (2) @(posedge i_clk);
    end
  endtask
  task automatic gate(input logic v);
    o_gate_a <= v;
    repeat (2) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// tb: register, counting, gating, split and interrupt scenarios for dctm_top
// assumes dctm_pkg, dctm_pin_model and the bound checker are compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] RUN = dctm_pkg::ADDR_RUN_CONTROL;
  localparam logic [7:0] MOD = dctm_pkg::ADDR_MODE_SELECT;
  localparam logic [7:0] ALO = dctm_pkg::ADDR_A_LOW;
  localparam logic [7:0] AHI = dctm_pkg::ADDR_A_HIGH;
  logic        i_clk, i_reset, cyc, stb, we, ack, en_a, en_b, vack_a, vack_b;
  logic        ev_a, ev_b, gt_a, gt_b, irq_a, irq_b, baud, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rnd;
  logic [31:0] rq[$];
  logic [7:0]  tm[5], th[5], tl[5], eh[5], el[5], er[5];
  int          tn[5];
  int          failures, compares;
  ////////////////////////////////////////////////////////////
  dctm_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_timer_a_event_pin(ev_a), .i_timer_b_event_pin(ev_b), .i_ext_gate_input_a(gt_a),
    .i_ext_gate_input_b(gt_b), .i_timer_a_irq_enable(en_a), .i_timer_b_irq_enable(en_b),
    .i_timer_a_vector_ack(vack_a), .i_timer_b_vector_ack(vack_b), .o_timer_a_irq(irq_a),
    .o_timer_b_irq(irq_b), .o_timer_b_baud_tick(baud), .o_irq(irq));
  dctm_pin_model pins (.i_clk(i_clk), .o_event_a(ev_a), .o_event_b(ev_b), .o_gate_a(gt_a), .o_gate_b(gt_b));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // holds the request until ack is sampled, then drops it for a cycle
  // no local limit: only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back({24'h000000, e});
    wb(1'b0, a, 8'h00);
  endtask
  // counts baud pulses over forty clocks
  task automatic baud_count(input int e);
    int n;
    n = 0;
    repeat (40) begin
      @(posedge i_clk);
      n += baud;
    end
    check(n, e);
  endtask
  always @(posedge i_clk) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
      check(rdat, rq.pop_front());
    end
  end
  task automatic final_report;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, vack_a, vack_b} = 5'h00;
    {en_a, en_b} = 2'b11;
    adr = 8'h00;
    wdat = 32'h00000000;
    i_reset = 1'b1;
    rnd = lfsr(32'h000029AE);
    tm = '{8'h04, 8'h04, 8'h05, 8'h05, 8'h06};
    th = '{8'h00, 8'hFF, 8'hFF, 8'hFF, rnd[7:0]};
    tl = '{8'h1E, 8'h1F, 8'hFE, 8'hFF, 8'hFF};
    tn = '{3, 1, 1, 1, 1};
    eh = '{8'h01, 8'h00, 8'hFF, 8'h00, rnd[7:0]};
    el = '{8'h01, 8'h00, 8'hFF, 8'h00, rnd[7:0]};
    er = '{8'h10, 8'h30, 8'h10, 8'h30, 8'h30};
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(RUN, 8'h00);
    rd(8'hFC, 8'h00);
    // preload then run, since setting run keeps the count
    for (int i = 0; i < 5; i++) begin
      wr(RUN, 8'h00);
      wr(MOD, tm[i]);
      wr(AHI, th[i]);
      wr(ALO, tl[i]);
      wr(RUN, 8'h10);
      pins.pulse(tn[i]);
      rd(ALO, el[i]);
      rd(AHI, eh[i]);
      rd(RUN, er[i]);
    end
    check(irq, 1'b0);
    wr(dctm_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge i_clk);
    check(irq, 1'b1);
    check(irq_a, 1'b1);
    rd(dctm_pkg::ADDR_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge i_clk);
    check(irq, 1'b0);
    vack_a <= 1'b1;
    @(posedge i_clk);
    vack_a <= 1'b0;
    repeat (3) @(posedge i_clk);
    check(irq_a, 1'b0);
    rd(RUN, 8'h10);
    wr(MOD, 8'h0C);
    for (int p = 0; p < 2; p++) begin
      wr(dctm_pkg::ADDR_INPUT_CONFIG, p ? 8'h08 : 8'h00);
      wr(ALO, 8'h00);
      wr(AHI, 8'h00);
      pins.gate(p == 0);
      pins.pulse(2);
      pins.gate(p == 1);
      pins.pulse(1);
      rd(ALO, 8'h01);
    end
    // prescaled clock at /4, counted only while the gate pin stands active for 40 clocks
    pins.gate(1'b0);
    wr(dctm_pkg::ADDR_CLOCK_SCALE, 8'h01);
    wr(MOD, 8'h09);
    wr(ALO, 8'h00);
    wr(AHI, 8'h00);
    pins.gate(1'b1);
    repeat (38) @(posedge i_clk);
    pins.gate(1'b0);
    rd(ALO, 8'h0A);
    // timer b on its own event pin
    wr(RUN, 8'h00);
    wr(MOD, 8'h40);
    wr(dctm_pkg::ADDR_B_LOW, 8'h00);
    wr(dctm_pkg::ADDR_B_HIGH, 8'h00);
    wr(RUN, 8'h40);
    pins.pulse_b(2);
    rd(dctm_pkg::ADDR_B_LOW, 8'h02);
    wr(RUN, 8'h00);
    wr(dctm_pkg::ADDR_CLOCK_SCALE, 8'h18);
    wr(MOD, 8'h07);
    wr(ALO, 8'hFF);
    wr(AHI, 8'hFF);
    wr(RUN, 8'h50);
    pins.pulse(1);
    rd(RUN, 8'hF0);
    check(irq_b, 1'b1);
    // b runs by mode alone during split; a reload of 0xFC gives a four-clock baud period
    wr(MOD, 8'h27);
    wr(dctm_pkg::ADDR_B_HIGH, 8'hFC);
    wr(dctm_pkg::ADDR_B_LOW, 8'hFC);
    baud_count(10);
    wr(MOD, 8'h37);
    baud_count(0);
    @(posedge i_clk);
    final_report();
  end
endmodule
`default_nettype wire
